// File: biu_consts.svh
`ifndef BIU_CONSTS_SVH
`define BIU_CONSTS_SVH

// register byte addresses (low address bits)
`define BIU_ADR_CTRL        8'h00
`define BIU_ADR_STATUS      8'h04
`define BIU_ADR_W           8

// control register fields
`define BIU_CTRL_FIQ_EN     0
`define BIU_CTRL_IRQ_EN     1
`define BIU_CTRL_RST        2'h0

// status register fields
`define BIU_ST_FIQ_ACT      0
`define BIU_ST_IRQ_ACT      1
`define BIU_ST_LOCK         2
`define BIU_ST_CP_BUSY      3
`define BIU_ST_ABORT_SEEN   4
`define BIU_ST_UNDEF_SEEN   5
`define BIU_ST_LATE_SEL     6
`define BIU_ST_DBE          7

// synchroniser layout and idle levels
`define BIU_SYNC_W          41
`define BIU_SYNC_RST        41'h0e0_0000_0000
`define BIU_S_MCLK          40
`define BIU_S_STALL_N       39
`define BIU_S_FIQ_N         38
`define BIU_S_IRQ_N         37
`define BIU_S_DBE           36
`define BIU_S_LATE          35
`define BIU_S_ABORT         34
`define BIU_S_CPA           33
`define BIU_S_CPB           32

`define BIU_WORD_ZERO       32'h0000_0000

`endif

// File: biu_pkg.sv
package biu_pkg;

   typedef enum logic [1:0]
   {
      BIU_CP_IDLE,
      BIU_CP_HAND,
      BIU_CP_RELEASE
   } biu_cp_state_t;

   typedef logic [31:0] biu_word_t;

endpackage

// File: biu_sync.sv
`timescale 1ns/1ps

module biu_sync #(
   parameter int                 WIDTH     = 1,
   parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
   input  wire logic             clk_i,
   input  wire logic             arst_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         meta_reg <= RESET_VAL;
         sync_reg <= RESET_VAL;
      end
      else
      begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;

endmodule // biu_sync

// File: biu_core.sv
// Behaviour
// - write data drivers are enabled only while the drive enable input is high
// - aborted single load/store writes back base only when late abort select high
// - lock stays high over locked accesses, changes in phase 2, swap only
// - all timing derives from main clock: low is phase 1, high-and-not-stalled phase 2
// - main clock may stop in either phase, or stall input slows a free clock
// - byte/word indicator is high for words, low for bytes, reads and writes
// - byte/word valid from phase 2 before transfer through phase 1 of it
// - coprocessor instruction drives request low and waits on absent and busy
// - absent high at end of phase 1 abandons handshake, raises undefined trap
// - busy sampled at end of each phase 1 with request low; wait while high
// - fast interrupt is asynchronous, level sensitive, taken when low and enabled
// - normal interrupt is like fast but gated by own enable, lower priority
// - memory request low announces next cycle access, from phase 1 of preceding
// - opcode fetch low for fetches, high for data, phase 2 through phase 1
// - stall low holds whole cycles, combined with clock high, changes in clock low
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "biu_consts.svh"

module biu_core (
   input  wire logic              clk_i,
   input  wire logic              arst_n_i,
   // wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   // processor pins
   input  wire logic              mclk_i,
   input  wire logic              stall_n_i,
   input  wire logic              data_bus_drive_enable_i,
   input  wire logic              late_abort_select_i,
   input  wire logic              mem_abort_i,
   input  wire logic              coproc_absent_i,
   input  wire logic              coproc_busy_i,
   input  wire logic              fast_intr_req_n_i,
   input  wire logic              normal_intr_req_n_i,
   input  wire logic [31:0]       data_i,
   output logic      [31:0]       data_o,
   output logic                   data_oe_o,
   output logic                   mem_request_n_o,
   output logic                   opcode_fetch_n_o,
   output logic                   byte_word_n_o,
   output logic                   lock_o,
   output logic                   coproc_request_n_o,
   // core side access request
   input  wire logic              acc_valid_i,
   input  wire logic              acc_fetch_i,
   input  wire logic              acc_word_i,
   input  wire logic              acc_write_i,
   input  wire logic              acc_swap_i,
   input  wire logic              acc_single_i,
   input  wire biu_pkg::biu_word_t acc_wdata_i,
   output logic                   acc_take_o,
   output logic                   xfer_done_o,
   output biu_pkg::biu_word_t     xfer_rdata_o,
   output logic                   xfer_abort_o,
   output logic                   base_writeback_o,
   // core side coprocessor and interrupts
   input  wire logic              cp_start_i,
   output logic                   cp_busy_o,
   output logic                   cp_done_o,
   output logic                   cp_undef_o,
   output logic                   fiq_take_o,
   output logic                   irq_take_o
);

   import biu_pkg::*;

   function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] target);
      reg_hit = (adr == target);
   endfunction

   // synchronised pins
   logic [`BIU_SYNC_W-1:0] pins_s;
   logic                   mclk_s;
   logic                   stall_n_s;
   logic                   fiq_n_s;
   logic                   irq_n_s;
   logic                   dbe_s;
   logic                   late_s;
   logic                   abort_s;
   logic                   cpa_s;
   logic                   cpb_s;
   biu_word_t              data_s;

   biu_sync #(
      .WIDTH     (`BIU_SYNC_W),
      .RESET_VAL (`BIU_SYNC_RST)
   ) u_sync (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .async_i  ({mclk_i, stall_n_i, fast_intr_req_n_i, normal_intr_req_n_i,
                  data_bus_drive_enable_i, late_abort_select_i, mem_abort_i,
                  coproc_absent_i, coproc_busy_i, data_i}),
      .sync_o   (pins_s)
   );

   assign mclk_s    = pins_s[`BIU_S_MCLK];
   assign stall_n_s = pins_s[`BIU_S_STALL_N];
   assign fiq_n_s   = pins_s[`BIU_S_FIQ_N];
   assign irq_n_s   = pins_s[`BIU_S_IRQ_N];
   assign dbe_s     = pins_s[`BIU_S_DBE];
   assign late_s    = pins_s[`BIU_S_LATE];
   assign abort_s   = pins_s[`BIU_S_ABORT];
   assign cpa_s     = pins_s[`BIU_S_CPA];
   assign cpb_s     = pins_s[`BIU_S_CPB];
   assign data_s    = pins_s[31:0];

   // phase tracking: nothing advances unless an edge arrives, so a held clock keeps state
   logic ph2;
   logic ph2_reg;
   logic ph2_start;
   logic cyc_bound;

   assign ph2       = mclk_s & stall_n_s;
   assign ph2_start = ph2 & ~ph2_reg;           // end of phase 1
   assign cyc_bound = ph2_reg & ~mclk_s;        // end of phase 2

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         ph2_reg <= 1'b0;
      else
         ph2_reg <= ph2;
   end

   // memory access pipeline
   logic      req_n_reg,  req_n_next;
   logic      opc_n_reg,  opc_n_next;
   logic      bw_n_reg,   bw_n_next;
   logic      lock_reg,   lock_next;
   logic      pend_reg,   pend_next;
   logic      pfetch_reg, pfetch_next;
   logic      pword_reg,  pword_next;
   logic      pwrite_reg, pwrite_next;
   logic      pswap_reg,  pswap_next;
   logic      psingle_reg, psingle_next;
   biu_word_t pwdata_reg, pwdata_next;
   logic      xact_reg,   xact_next;
   logic      xwrite_reg, xwrite_next;
   logic      xsingle_reg, xsingle_next;
   biu_word_t wdata_reg,  wdata_next;
   biu_word_t rdata_reg,  rdata_next;
   logic      take_reg,   take_next;
   logic      done_reg,   done_next;
   logic      abt_reg,    abt_next;
   logic      bwb_reg,    bwb_next;

   always_comb
   begin
      req_n_next   = req_n_reg;
      opc_n_next   = opc_n_reg;
      bw_n_next    = bw_n_reg;
      lock_next    = lock_reg;
      pend_next    = pend_reg;
      pfetch_next  = pfetch_reg;
      pword_next   = pword_reg;
      pwrite_next  = pwrite_reg;
      pswap_next   = pswap_reg;
      psingle_next = psingle_reg;
      pwdata_next  = pwdata_reg;
      xact_next    = xact_reg;
      xwrite_next  = xwrite_reg;
      xsingle_next = xsingle_reg;
      wdata_next   = wdata_reg;
      rdata_next   = rdata_reg;
      take_next    = 1'b0;
      done_next    = 1'b0;
      abt_next     = 1'b0;
      bwb_next     = 1'b0;
      if (cyc_bound)
      begin
         // finish the transfer of the cycle that just ended
         if (xact_reg)
         begin
            done_next = 1'b1;
            if (!xwrite_reg)
               rdata_next = data_s;
            if (abort_s && xsingle_reg)
            begin
               abt_next = 1'b1;
               bwb_next = late_s;
            end
         end
         // announced access becomes the transfer of the new cycle
         xact_next    = pend_reg;
         xwrite_next  = pwrite_reg;
         xsingle_next = psingle_reg;
         if (pend_reg)
            wdata_next = pwdata_reg;
         // announce the access of the following cycle from phase 1
         pend_next    = acc_valid_i;
         req_n_next   = ~acc_valid_i;
         take_next    = acc_valid_i;
         if (acc_valid_i)
         begin
            pfetch_next  = acc_fetch_i;
            pword_next   = acc_word_i;
            pwrite_next  = acc_write_i;
            pswap_next   = acc_swap_i;
            psingle_next = acc_single_i;
            pwdata_next  = acc_wdata_i;
         end
      end
      if (ph2_start)
      begin
         if (pend_reg)
         begin
            opc_n_next = ~pfetch_reg;
            bw_n_next  = pword_reg;
         end
         lock_next = pend_reg & pswap_reg;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         req_n_reg   <= 1'b1;
         opc_n_reg   <= 1'b1;
         bw_n_reg    <= 1'b1;
         lock_reg    <= 1'b0;
         pend_reg    <= 1'b0;
         pfetch_reg  <= 1'b0;
         pword_reg   <= 1'b0;
         pwrite_reg  <= 1'b0;
         pswap_reg   <= 1'b0;
         psingle_reg <= 1'b0;
         pwdata_reg  <= `BIU_WORD_ZERO;
         xact_reg    <= 1'b0;
         xwrite_reg  <= 1'b0;
         xsingle_reg <= 1'b0;
         wdata_reg   <= `BIU_WORD_ZERO;
         rdata_reg   <= `BIU_WORD_ZERO;
         take_reg    <= 1'b0;
         done_reg    <= 1'b0;
         abt_reg     <= 1'b0;
         bwb_reg     <= 1'b0;
      end
      else
      begin
         req_n_reg   <= req_n_next;
         opc_n_reg   <= opc_n_next;
         bw_n_reg    <= bw_n_next;
         lock_reg    <= lock_next;
         pend_reg    <= pend_next;
         pfetch_reg  <= pfetch_next;
         pword_reg   <= pword_next;
         pwrite_reg  <= pwrite_next;
         pswap_reg   <= pswap_next;
         psingle_reg <= psingle_next;
         pwdata_reg  <= pwdata_next;
         xact_reg    <= xact_next;
         xwrite_reg  <= xwrite_next;
         xsingle_reg <= xsingle_next;
         wdata_reg   <= wdata_next;
         rdata_reg   <= rdata_next;
         take_reg    <= take_next;
         done_reg    <= done_next;
         abt_reg     <= abt_next;
         bwb_reg     <= bwb_next;
      end
   end

   // coprocessor handshake
   biu_cp_state_t cp_state_reg, cp_state_next;
   logic          cpi_n_reg,    cpi_n_next;
   logic          cpdone_reg,   cpdone_next;
   logic          cpundef_reg,  cpundef_next;

   always_comb
   begin
      cp_state_next = cp_state_reg;
      cpi_n_next    = cpi_n_reg;
      cpdone_next   = 1'b0;
      cpundef_next  = 1'b0;
      unique case (cp_state_reg)
         BIU_CP_IDLE:
         begin
            if (cyc_bound && cp_start_i)
            begin
               cpi_n_next    = 1'b0;
               cp_state_next = BIU_CP_HAND;
            end
         end
         BIU_CP_HAND:
         begin
            if (ph2_start)
            begin
               if (cpa_s)
               begin
                  cpundef_next  = 1'b1;
                  cp_state_next = BIU_CP_RELEASE;
               end
               else if (!cpb_s)
               begin
                  cpdone_next   = 1'b1;
                  cp_state_next = BIU_CP_RELEASE;
               end
            end
         end
         BIU_CP_RELEASE:
         begin
            if (cyc_bound)
            begin
               cpi_n_next    = 1'b1;
               cp_state_next = BIU_CP_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cp_state_reg <= BIU_CP_IDLE;
         cpi_n_reg    <= 1'b1;
         cpdone_reg   <= 1'b0;
         cpundef_reg  <= 1'b0;
      end
      else
      begin
         cp_state_reg <= cp_state_next;
         cpi_n_reg    <= cpi_n_next;
         cpdone_reg   <= cpdone_next;
         cpundef_reg  <= cpundef_next;
      end
   end

   // wishbone registers and interrupt gating
   logic [1:0] ctrl_reg,  ctrl_next;
   logic       abseen_reg, abseen_next;
   logic       unseen_reg, unseen_next;
   logic       ack_reg,   ack_next;
   biu_word_t  rd_reg,    rd_next;
   logic       fiq_reg,   fiq_next;
   logic       irq_reg,   irq_next;
   logic       wr_go;
   biu_word_t  status;

   assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & wb_sel_i[0];

   always_comb
   begin
      status = `BIU_WORD_ZERO;
      status[`BIU_ST_FIQ_ACT]    = ~fiq_n_s;
      status[`BIU_ST_IRQ_ACT]    = ~irq_n_s;
      status[`BIU_ST_LOCK]       = lock_reg;
      status[`BIU_ST_CP_BUSY]    = (cp_state_reg != BIU_CP_IDLE);
      status[`BIU_ST_ABORT_SEEN] = abseen_reg;
      status[`BIU_ST_UNDEF_SEEN] = unseen_reg;
      status[`BIU_ST_LATE_SEL]   = late_s;
      status[`BIU_ST_DBE]        = dbe_s;
      ctrl_next   = ctrl_reg;
      abseen_next = abseen_reg;
      unseen_next = unseen_reg;
      ack_next    = wb_cyc_i & wb_stb_i & ~ack_reg;
      rd_next     = rd_reg;
      if (wr_go && reg_hit(wb_adr_i, `BIU_ADR_CTRL))
         ctrl_next = wb_dat_i[1:0];
      if (wr_go && reg_hit(wb_adr_i, `BIU_ADR_STATUS))
      begin
         if (wb_dat_i[`BIU_ST_ABORT_SEEN])
            abseen_next = 1'b0;
         if (wb_dat_i[`BIU_ST_UNDEF_SEEN])
            unseen_next = 1'b0;
      end
      // set wins over a clear in the same cycle
      if (abt_reg)
         abseen_next = 1'b1;
      if (cpundef_reg)
         unseen_next = 1'b1;
      if (ack_next)
      begin
         rd_next = `BIU_WORD_ZERO;
         if (reg_hit(wb_adr_i, `BIU_ADR_CTRL))
            rd_next[1:0] = ctrl_reg;
         else if (reg_hit(wb_adr_i, `BIU_ADR_STATUS))
            rd_next = status;
      end
      fiq_next = ~fiq_n_s & ctrl_reg[`BIU_CTRL_FIQ_EN];
      irq_next = ~irq_n_s & ctrl_reg[`BIU_CTRL_IRQ_EN] & ~fiq_next;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ctrl_reg   <= `BIU_CTRL_RST;
         abseen_reg <= 1'b0;
         unseen_reg <= 1'b0;
         ack_reg    <= 1'b0;
         rd_reg     <= `BIU_WORD_ZERO;
         fiq_reg    <= 1'b0;
         irq_reg    <= 1'b0;
      end
      else
      begin
         ctrl_reg   <= ctrl_next;
         abseen_reg <= abseen_next;
         unseen_reg <= unseen_next;
         ack_reg    <= ack_next;
         rd_reg     <= rd_next;
         fiq_reg    <= fiq_next;
         irq_reg    <= irq_next;
      end
   end

   assign wb_ack_o           = ack_reg;
   assign wb_dat_o           = rd_reg;
   assign data_o             = wdata_reg;
   assign data_oe_o          = xact_reg & xwrite_reg & dbe_s;
   assign mem_request_n_o    = req_n_reg;
   assign opcode_fetch_n_o   = opc_n_reg;
   assign byte_word_n_o      = bw_n_reg;
   assign lock_o             = lock_reg;
   assign coproc_request_n_o = cpi_n_reg;
   assign acc_take_o         = take_reg;
   assign xfer_done_o        = done_reg;
   assign xfer_rdata_o       = rdata_reg;
   assign xfer_abort_o       = abt_reg;
   assign base_writeback_o   = bwb_reg;
   assign cp_busy_o          = (cp_state_reg != BIU_CP_IDLE);
   assign cp_done_o          = cpdone_reg;
   assign cp_undef_o         = cpundef_reg;
   assign fiq_take_o         = fiq_reg;
   assign irq_take_o         = irq_reg;

endmodule // biu_core

// File: biu_core_asserts.sv
`timescale 1ns/1ps

module biu_core_chk (
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   input  wire logic wb_cyc_i,
   input  wire logic wb_stb_i,
   input  wire logic wb_ack_o,
   input  wire logic mclk_i,
   input  wire logic data_bus_drive_enable_i,
   input  wire logic coproc_absent_i,
   input  wire logic coproc_busy_i,
   input  wire logic fast_intr_req_n_i,
   input  wire logic data_oe_o,
   input  wire logic mem_request_n_o,
   input  wire logic opcode_fetch_n_o,
   input  wire logic byte_word_n_o,
   input  wire logic lock_o,
   input  wire logic coproc_request_n_o,
   input  wire logic xfer_abort_o,
   input  wire logic base_writeback_o,
   input  wire logic cp_done_o,
   input  wire logic cp_undef_o,
   input  wire logic fiq_take_o,
   input  wire logic irq_take_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   a_oe_needs_dbe: assert property (!data_bus_drive_enable_i [*4] |-> !data_oe_o)
      else $error("data driven while drive enable low");
   a_bwb_with_abort: assert property (base_writeback_o |-> xfer_abort_o)
      else $error("base writeback without abort");
   a_lock_in_ph2: assert property ($changed(lock_o) |->
      $past(mclk_i, 2) || $past(mclk_i, 3) || $past(mclk_i, 4))
      else $error("lock changed outside clock high");
   a_pipe_in_ph2: assert property ($changed(opcode_fetch_n_o) || $changed(byte_word_n_o) |->
      $past(mclk_i, 2) || $past(mclk_i, 3) || $past(mclk_i, 4))
      else $error("fetch or width indicator changed outside clock high");
   a_req_in_ph1: assert property ($changed(mem_request_n_o) |->
      !$past(mclk_i, 2) || !$past(mclk_i, 3) || !$past(mclk_i, 4))
      else $error("memory request changed outside clock low");
   a_undef_on_absent: assert property (cp_undef_o |->
      !coproc_request_n_o && $past(coproc_absent_i, 3))
      else $error("undefined trap without absent coprocessor");
   a_done_not_busy: assert property (cp_done_o |->
      !coproc_request_n_o && !$past(coproc_busy_i, 3) && !cp_undef_o)
      else $error("coprocessor done while busy");
   a_fiq_needs_pin: assert property (fiq_take_o |-> !$past(fast_intr_req_n_i, 2) ||
      !$past(fast_intr_req_n_i, 3) || !$past(fast_intr_req_n_i, 4))
      else $error("fast interrupt taken without request");
   a_irq_below_fiq: assert property (!(fiq_take_o && irq_take_o))
      else $error("both interrupts taken together");
   a_wb_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not acknowledged");
   a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
endmodule // biu_core_chk

bind biu_core biu_core_chk i_chk (.clk_i, .arst_n_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .mclk_i,
   .data_bus_drive_enable_i, .coproc_absent_i, .coproc_busy_i, .fast_intr_req_n_i, .data_oe_o,
   .mem_request_n_o, .opcode_fetch_n_o, .byte_word_n_o, .lock_o, .coproc_request_n_o,
   .xfer_abort_o, .base_writeback_o, .cp_done_o, .cp_undef_o, .fiq_take_o, .irq_take_o);

// File: biu_far_model.sv
`timescale 1ns/1ps

module biu_far_model #(
   parameter logic [31:0] RDATA = 32'ha5c3_0f96
) (
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        coproc_request_n_i,
   input  wire logic        absent_mode_i,
   input  wire logic [1:0]  busy_cycles_i,
   output logic             mclk_o,
   output logic             stall_n_o,
   output logic [31:0]      data_o,
   output logic             coproc_absent_o,
   output logic             coproc_busy_o
);
   logic [2:0] ph_cnt_reg;
   logic [1:0] cyc_cnt_reg;
   logic [1:0] busy_cnt_reg;

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ph_cnt_reg <= 3'h0;
         cyc_cnt_reg <= 2'h0;
         busy_cnt_reg <= 2'h0;
      end
      else
      begin
         ph_cnt_reg <= ph_cnt_reg + 3'h1;
         if (ph_cnt_reg == 3'h0)
            cyc_cnt_reg <= cyc_cnt_reg + 2'h1;
         if (coproc_request_n_i)
            busy_cnt_reg <= busy_cycles_i;
         else if (ph_cnt_reg == 3'h7 && busy_cnt_reg != 2'h0)
            busy_cnt_reg <= busy_cnt_reg - 2'h1;
      end
   end

   // free clock, every fourth cycle stalled; stall moves only while clock is low
   assign mclk_o = ph_cnt_reg[2];
   assign stall_n_o = (cyc_cnt_reg != 2'h3);
   // read data held over phase 2 and a short hold, inverted elsewhere
   assign data_o = (ph_cnt_reg[2] || ph_cnt_reg < 3'h2) ? RDATA : ~RDATA;
   assign coproc_absent_o = absent_mode_i | coproc_request_n_i;
   assign coproc_busy_o = !coproc_request_n_i && busy_cnt_reg != 2'h0;
endmodule // biu_far_model

// File: test_biu_core.sv
`timescale 1ns/1ps

module test_biu_core;
   import biu_pkg::*;
   localparam logic [31:0] RDATA = 32'h5e1c_7a30;
   logic clk_i = 1'b0, arst_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, data_i, data_o, rd, wd_seen, r;
   logic data_bus_drive_enable_i = 1'b0, late_abort_select_i = 1'b0, mem_abort_i = 1'b0;
   logic fast_intr_req_n_i = 1'b1, normal_intr_req_n_i = 1'b1, cp_start_i = 1'b0;
   logic acc_valid_i = 1'b0, acc_fetch_i = 1'b0, acc_word_i = 1'b0, acc_write_i = 1'b0;
   logic acc_swap_i = 1'b0, acc_single_i = 1'b0, absent_mode = 1'b0;
   logic [1:0] busy_cycles = 2'h0;
   biu_word_t acc_wdata_i = 32'h0000_0000, xfer_rdata_o;
   logic wb_ack_o, mclk_i, stall_n_i, coproc_absent_i, coproc_busy_i, data_oe_o, lock_o;
   logic mem_request_n_o, opcode_fetch_n_o, byte_word_n_o, coproc_request_n_o, acc_take_o;
   logic xfer_done_o, xfer_abort_o, base_writeback_o, cp_busy_o, cp_done_o, cp_undef_o;
   logic fiq_take_o, irq_take_o, lock_seen, oe_seen;
   int fails = 0, comparisons = 0, seed = 32'hce9d;

   always #4 clk_i = ~clk_i;

   biu_core i_dut (.clk_i, .arst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .mclk_i, .stall_n_i, .data_bus_drive_enable_i,
      .late_abort_select_i, .mem_abort_i, .coproc_absent_i, .coproc_busy_i, .fast_intr_req_n_i,
      .normal_intr_req_n_i, .data_i, .data_o, .data_oe_o, .mem_request_n_o, .opcode_fetch_n_o,
      .byte_word_n_o, .lock_o, .coproc_request_n_o, .acc_valid_i, .acc_fetch_i, .acc_word_i,
      .acc_write_i, .acc_swap_i, .acc_single_i, .acc_wdata_i, .acc_take_o, .xfer_done_o,
      .xfer_rdata_o, .xfer_abort_o, .base_writeback_o, .cp_start_i, .cp_busy_o, .cp_done_o,
      .cp_undef_o, .fiq_take_o, .irq_take_o);

   biu_far_model #(.RDATA(RDATA)) i_far (.clk_i, .arst_n_i,
      .coproc_request_n_i(coproc_request_n_o), .absent_mode_i(absent_mode),
      .busy_cycles_i(busy_cycles), .mclk_o(mclk_i), .stall_n_o(stall_n_i), .data_o(data_i),
      .coproc_absent_o(coproc_absent_i), .coproc_busy_o(coproc_busy_i));

   always @(posedge clk_i)
   begin
      if (lock_o === 1'b1)
         lock_seen <= 1'b1;
      if (data_oe_o === 1'b1)
         oe_seen <= 1'b1;
      if (data_oe_o === 1'b1)
         wd_seen <= data_o;
   end

   task automatic final_report;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk1(input string nm, input logic exp, input logic got);
      chk(nm, {31'h0, exp}, {31'h0, got});
   endtask

   task automatic wait_on(input int which);
      for (int n = 0; n < 300; n++)
      begin
         @(posedge clk_i);
         #1;
         if ((which == 0 && acc_take_o === 1'b1) || (which == 1 && xfer_done_o === 1'b1) ||
             (which == 2 && (cp_done_o === 1'b1 || cp_undef_o === 1'b1)) ||
             (which == 3 && coproc_request_n_o === 1'b0) || (which == 4 && wb_ack_o === 1'b1))
            return;
      end
      $display("[FAIL] wait %0d expected 1 seen 0", which);
      fails++;
      final_report();
   endtask

   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wait_on(4);
      @(posedge clk_i);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   initial
   begin
      repeat (10) @(posedge clk_i);
      arst_n_i <= 1'b1;
      wb(1'b0, 8'h00, 32'h0000_0000);
      chk("ctrl reset", 32'h0000_0000, rd);
      wb(1'b1, 8'h00, 32'hffff_ffff);
      wb(1'b0, 8'h00, 32'h0000_0000);
      chk("ctrl write", 32'h0000_0003, rd);
      wb(1'b1, 8'h40, 32'h1234_5678);
      wb(1'b0, 8'h40, 32'h0000_0000);
      chk("unmapped read", 32'h0000_0000, rd);
      @(posedge clk_i);
      data_bus_drive_enable_i <= 1'b1;
      late_abort_select_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      wb(1'b0, 8'h04, 32'h0000_0000);
      chk("status pins", 32'h0000_0003, {30'h0, rd[7:6]});
      $display("test registers done");
      // sources hold requests low until the take is checked
      @(posedge clk_i);
      fast_intr_req_n_i <= 1'b0;
      normal_intr_req_n_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      #1;
      chk1("fiq take", 1'b1, fiq_take_o);
      chk1("irq masked", 1'b0, irq_take_o);
      @(posedge clk_i);
      fast_intr_req_n_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      #1;
      chk1("fiq released", 1'b0, fiq_take_o);
      chk1("irq take", 1'b1, irq_take_o);
      wb(1'b1, 8'h00, 32'h0000_0001);
      repeat (6) @(posedge clk_i);
      #1;
      chk1("irq disabled", 1'b0, irq_take_o);
      @(posedge clk_i);
      normal_intr_req_n_i <= 1'b1;
      $display("test interrupts done");
      for (int i = 0; i < 16; i++)
      begin
         r = $random(seed);
         if (i < 2)
            r[7:0] = i[0] ? 8'h7a : 8'h58;
         repeat (3) @(posedge clk_i);
         lock_seen = 1'b0;
         oe_seen = 1'b0;
         @(posedge clk_i);
         acc_valid_i <= 1'b1;
         acc_fetch_i <= r[0];
         acc_word_i <= r[1];
         acc_swap_i <= !r[0] && r[2];
         acc_write_i <= !r[0] && r[3];
         acc_single_i <= !r[0] && !r[2];
         acc_wdata_i <= $random(seed);
         mem_abort_i <= !r[0] && !r[2] && r[4];
         late_abort_select_i <= r[5] | r[7];
         data_bus_drive_enable_i <= r[6];
         wait_on(0);
         chk1("request low", 1'b0, mem_request_n_o);
         @(posedge clk_i);
         acc_valid_i <= 1'b0;
         wait_on(1);
         chk1("byte word", acc_word_i, byte_word_n_o);
         chk1("opcode fetch", !acc_fetch_i, opcode_fetch_n_o);
         chk1("lock", acc_swap_i, lock_seen);
         chk1("drive enable", acc_write_i & data_bus_drive_enable_i, oe_seen);
         chk1("abort", mem_abort_i, xfer_abort_o);
         chk1("base writeback", mem_abort_i & late_abort_select_i, base_writeback_o);
         if (!acc_write_i && !mem_abort_i)
            chk("read data", RDATA, xfer_rdata_o);
         if (acc_write_i && data_bus_drive_enable_i)
            chk("write data", acc_wdata_i, wd_seen);
      end
      $display("test memory done");
      for (int m = 0; m < 3; m++)
      begin
         @(posedge clk_i);
         absent_mode <= (m == 0);
         busy_cycles <= (m == 2) ? 2'h2 : 2'h0;
         cp_start_i <= 1'b1;
         wait_on(3);
         chk1("cp busy", 1'b1, cp_busy_o);
         @(posedge clk_i);
         cp_start_i <= 1'b0;
         wait_on(2);
         chk1("cp undef", m == 0, cp_undef_o);
         chk1("cp done", m != 0, cp_done_o);
         repeat (20) @(posedge clk_i);
      end
      wb(1'b0, 8'h04, 32'h0000_0000);
      chk("sticky flags", 32'h0000_0030, {26'h0, rd[5:0]});
      wb(1'b1, 8'h04, 32'h0000_0030);
      wb(1'b0, 8'h04, 32'h0000_0000);
      chk("sticky cleared", 32'h0000_0000, {26'h0, rd[5:0]});
      $display("test coprocessor done");
      final_report();
   end
endmodule // test_biu_core
